// file: core/sdm_map.vh
// Command codes, access size codes, status values and bus constants for the debug monitor
`ifndef SDM_MAP_VH
`define SDM_MAP_VH
`define SDM_CMD_LIMIT 8'h20
`define SDM_CMD_SET_LITERAL 5'h00
`define SDM_CMD_TRANSMIT 5'h02
`define SDM_CMD_RD_BYTE 5'h04
`define SDM_CMD_RD_WORD 5'h05
`define SDM_CMD_RD_DWORD 5'h06
`define SDM_CMD_WR_BYTE 5'h07
`define SDM_CMD_WR_WORD 5'h08
`define SDM_CMD_WR_DWORD 5'h09
`define SDM_CMD_LOAD_ADDR 5'h0a
`define SDM_CMD_INDIRECT 5'h0b
`define SDM_CMD_RD_STATUS 5'h0c
`define SDM_CMD_WR_STATUS 5'h0d
`define SDM_CMD_RD_SP 5'h0e
`define SDM_CMD_WR_SP 5'h0f
`define SDM_CMD_RD_PC 5'h10
`define SDM_CMD_WR_PC 5'h11
`define SDM_CMD_START 5'h12
`define SDM_CMD_STOP 5'h13
`define SDM_CMD_REPORT 5'h14
`define SDM_CMD_ESCAPE 5'h15
`define SDM_STAT_STOPPED 16'h0000
`define SDM_STAT_RUNNING 16'h0001
`define SDM_STAT_TRAPPED 16'h0002
`define SDM_ESC_RESET 16'h0001
`define SDM_IDLE_PC 16'h0000
`define SDM_IDLE_STATUS 16'h0000
`define SDM_SZ_BYTE 2'h0
`define SDM_SZ_WORD 2'h1
`define SDM_SZ_DWORD 2'h2
`define SDM_ADDR_RXDATA 32'h0000_0000
`define SDM_ADDR_RXSTAT 32'h0000_0004
`define SDM_ADDR_TXDATA 32'h0000_0008
`define SDM_ADDR_STATE 32'h0000_000c
`define SDM_ADDR_SHIFT 32'h0000_0010
`define SDM_ADDR_TADDR 32'h0000_0014
`define SDM_ADDR_USTAT 32'h0000_0018
`define SDM_ADDR_UPC 32'h0000_001c
`define SDM_ADDR_USP 32'h0000_0020
`define SDM_ADDR_CTRL 32'h0000_0024
`endif

// file: core/sdm_char_class.v
// Character classifier: splits a received character into command or data
`timescale 1ns/1ps
`default_nettype none
`include "sdm_map.vh"
module sdm_char_class (
   // Character in
   input wire [7:0] rxChar,
   input wire literalNextFlag,
   // Class out
   output wire isCommand
);
   // A pending literal-next forces data whatever the value
   assign isCommand = (rxChar < `SDM_CMD_LIMIT) && !literalNextFlag;
endmodule
`default_nettype wire

// file: core/sdm_debug_monitor.v
// Debug monitor command interpreter with AHB-Lite register access and target memory port
//
// Functional notes
// - Characters below 32 are commands, else data
// - Literal-next forces one character to data
// - Data byte shifts into data register low
// - Code 00h sets literal-next flag
// - Transmit: send low byte, shift right, addr++
// - Send bytes only on transmit command
// - Reads fetch byte, word, dword at address
// - Writes store then advance address 1/2/4
// - Code 0Ah loads address from low word
// - Code 0Bh loads address from memory word
// - Read/write user status word, run-aware
// - Stack pointer access; write pushes idle context
// - Read/write user program counter, run-aware
// - Start: clear halt, set run, resume user
// - Stop: clear run, save user context
// - Breakpoint entry while idle and running sets halt and stops in one cycle
// - Report 0 stopped, 1 running
// - Report 2 when halted by breakpoint
// - Escape with low word one resets target
// - Target address register is 16 bits
`timescale 1ns/1ps
`default_nettype none
`include "sdm_map.vh"
module sdm_debug_monitor (
   // Clock and reset
   input wire sys_clk,
   input wire rst_b,
   // AHB-Lite slave
   input wire hsel,
   input wire [31:0] haddr,
   input wire [1:0] htrans,
   input wire hwrite,
   input wire [2:0] hsize,
   input wire [31:0] hwdata,
   input wire hready,
   output reg [31:0] hrdata,
   output reg hreadyout,
   output reg hresp,
   // Target memory port
   output reg memReq,
   output reg memWrite,
   output reg [1:0] memSize,
   output reg [15:0] memAddr,
   output reg [31:0] memWdata,
   input wire memAck,
   input wire [31:0] memRdata,
   // Processor context
   input wire breakpointEntry,
   input wire [15:0] liveStatusWord,
   input wire [15:0] livePc,
   output reg targetReset,
   output reg userRunning
);
   localparam ST_IDLE = 2'h0;
   localparam ST_MEM = 2'h1;
   localparam ST_PUSH = 2'h2;

   reg [31:0] shift_data_reg, shift_data_next;
   reg [15:0] target_addr_reg, target_addr_next;
   reg literal_next_flag_reg, literal_next_flag_next;
   reg run_flag_reg, run_flag_next;
   reg halt_flag_reg, halt_flag_next;
   reg [15:0] saved_user_status_word_reg, saved_user_status_word_next;
   reg [15:0] saved_a_reg, saved_a_next;
   reg [15:0] user_sp_reg, user_sp_next;
   reg [1:0] state_reg, state_next;
   reg [4:0] pendCmd_reg, pendCmd_next;
   reg [7:0] rxChar_reg;
   reg rxFull_reg;
   reg [7:0] txData_reg;
   reg txFull_reg;
   reg memReq_next, memWrite_next;
   reg [1:0] memSize_next;
   reg [15:0] memAddr_next;
   reg [31:0] memWdata_next;
   reg targetReset_next;
   reg txLoad;
   reg rxTake;
   reg dphValid_reg, dphWrite_reg;
   reg [31:0] dphAddr_reg;
   wire isCommand;
   wire [4:0] cmd = rxChar_reg[4:0];
   wire busy = (state_reg != ST_IDLE);

   sdm_char_class uClass (
      .rxChar(rxChar_reg),
      .literalNextFlag(literal_next_flag_reg),
      .isCommand(isCommand)
   );

   // Command execution; only one character is acted on while idle
   always @* begin
      shift_data_next = shift_data_reg;
      target_addr_next = target_addr_reg;
      literal_next_flag_next = literal_next_flag_reg;
      run_flag_next = run_flag_reg;
      halt_flag_next = halt_flag_reg;
      saved_user_status_word_next = saved_user_status_word_reg;
      saved_a_next = saved_a_reg;
      user_sp_next = user_sp_reg;
      state_next = state_reg;
      pendCmd_next = pendCmd_reg;
      memReq_next = memReq;
      memWrite_next = memWrite;
      memSize_next = memSize;
      memAddr_next = memAddr;
      memWdata_next = memWdata;
      targetReset_next = 1'b0;
      txLoad = 1'b0;
      rxTake = 1'b0;
      case (state_reg)
         ST_IDLE: begin
            if (breakpointEntry && run_flag_reg) begin
               // Breakpoint takes priority over a waiting character
               halt_flag_next = 1'b1;
               run_flag_next = 1'b0;
               saved_a_next = livePc;
               saved_user_status_word_next = liveStatusWord;
            end else if (rxFull_reg && !(isCommand && cmd == `SDM_CMD_TRANSMIT && txFull_reg)) begin
               rxTake = 1'b1;
               if (!isCommand) begin
                  shift_data_next = {shift_data_reg[23:0], rxChar_reg};
                  literal_next_flag_next = 1'b0;
               end else begin
                  case (cmd)
                     `SDM_CMD_SET_LITERAL: literal_next_flag_next = 1'b1;
                     `SDM_CMD_TRANSMIT: begin
                        txLoad = 1'b1;
                        shift_data_next = {8'h00, shift_data_reg[31:8]};
                        target_addr_next = target_addr_reg + 16'h0001;
                     end
                     `SDM_CMD_RD_BYTE, `SDM_CMD_RD_WORD, `SDM_CMD_RD_DWORD, `SDM_CMD_INDIRECT: begin
                        memReq_next = 1'b1;
                        memWrite_next = 1'b0;
                        memAddr_next = target_addr_reg;
                        memSize_next = (cmd == `SDM_CMD_RD_BYTE) ? `SDM_SZ_BYTE :
                           (cmd == `SDM_CMD_RD_DWORD) ? `SDM_SZ_DWORD : `SDM_SZ_WORD;
                        pendCmd_next = cmd;
                        state_next = ST_MEM;
                     end
                     `SDM_CMD_WR_BYTE, `SDM_CMD_WR_WORD, `SDM_CMD_WR_DWORD: begin
                        memReq_next = 1'b1;
                        memWrite_next = 1'b1;
                        memAddr_next = target_addr_reg;
                        memWdata_next = shift_data_reg;
                        memSize_next = (cmd == `SDM_CMD_WR_BYTE) ? `SDM_SZ_BYTE :
                           (cmd == `SDM_CMD_WR_WORD) ? `SDM_SZ_WORD : `SDM_SZ_DWORD;
                        pendCmd_next = cmd;
                        state_next = ST_MEM;
                     end
                     `SDM_CMD_LOAD_ADDR: target_addr_next = shift_data_reg[15:0];
                     `SDM_CMD_RD_STATUS: shift_data_next = {16'h0000, run_flag_reg ? liveStatusWord
                        : saved_user_status_word_reg};
                     `SDM_CMD_WR_STATUS: saved_user_status_word_next = shift_data_reg[15:0];
                     `SDM_CMD_RD_SP: shift_data_next = {16'h0000, user_sp_reg};
                     `SDM_CMD_WR_SP: begin
                        // Two words pushed below the written pointer: idle PC then idle status word
                        user_sp_next = shift_data_reg[15:0] - 16'h0004;
                        memReq_next = 1'b1;
                        memWrite_next = 1'b1;
                        memSize_next = `SDM_SZ_WORD;
                        memAddr_next = shift_data_reg[15:0] - 16'h0002;
                        memWdata_next = {16'h0000, `SDM_IDLE_PC};
                        state_next = ST_PUSH;
                     end
                     `SDM_CMD_RD_PC: shift_data_next = {16'h0000, run_flag_reg ? livePc : saved_a_reg};
                     `SDM_CMD_WR_PC: saved_a_next = shift_data_reg[15:0];
                     `SDM_CMD_START: if (!run_flag_reg) begin
                        halt_flag_next = 1'b0;
                        run_flag_next = 1'b1;
                     end
                     `SDM_CMD_STOP: if (run_flag_reg) begin
                        run_flag_next = 1'b0;
                        saved_a_next = livePc;
                        saved_user_status_word_next = liveStatusWord;
                     end
                     `SDM_CMD_REPORT: shift_data_next = {shift_data_reg[31:16], run_flag_reg ?
                        `SDM_STAT_RUNNING : halt_flag_reg ? `SDM_STAT_TRAPPED : `SDM_STAT_STOPPED};
                     `SDM_CMD_ESCAPE: if (shift_data_reg[15:0] == `SDM_ESC_RESET) begin
                        targetReset_next = 1'b1;
                     end
                     default: ;
                  endcase
               end
            end
         end
         ST_MEM: if (memAck) begin
            memReq_next = 1'b0;
            state_next = ST_IDLE;
            case (pendCmd_reg)
               `SDM_CMD_RD_BYTE: shift_data_next = {shift_data_reg[31:8], memRdata[7:0]};
               `SDM_CMD_RD_WORD: shift_data_next = {shift_data_reg[31:16], memRdata[15:0]};
               `SDM_CMD_RD_DWORD: shift_data_next = memRdata;
               `SDM_CMD_INDIRECT: target_addr_next = memRdata[15:0];
               `SDM_CMD_WR_BYTE: target_addr_next = target_addr_reg + 16'h0001;
               `SDM_CMD_WR_WORD: target_addr_next = target_addr_reg + 16'h0002;
               `SDM_CMD_WR_DWORD: target_addr_next = target_addr_reg + 16'h0004;
               default: ;
            endcase
         end
         ST_PUSH: if (memAck) begin
            if (memAddr == user_sp_reg) begin
               memReq_next = 1'b0;
               state_next = ST_IDLE;
            end else begin
               memAddr_next = user_sp_reg;
               memWdata_next = {16'h0000, `SDM_IDLE_STATUS};
            end
         end
         default: state_next = ST_IDLE;
      endcase
   end

   // State registers
   always @(posedge sys_clk) begin
      if (!rst_b) begin
         shift_data_reg <= 32'h0000_0000;
         target_addr_reg <= 16'h0000;
         literal_next_flag_reg <= 1'b0;
         run_flag_reg <= 1'b0;
         halt_flag_reg <= 1'b0;
         saved_user_status_word_reg <= 16'h0000;
         saved_a_reg <= 16'h0000;
         user_sp_reg <= 16'h0000;
         state_reg <= ST_IDLE;
         pendCmd_reg <= 5'h00;
         memReq <= 1'b0;
         memWrite <= 1'b0;
         memSize <= 2'h0;
         memAddr <= 16'h0000;
         memWdata <= 32'h0000_0000;
         targetReset <= 1'b0;
         userRunning <= 1'b0;
      end else begin
         shift_data_reg <= shift_data_next;
         target_addr_reg <= target_addr_next;
         literal_next_flag_reg <= literal_next_flag_next;
         run_flag_reg <= run_flag_next;
         halt_flag_reg <= halt_flag_next;
         saved_user_status_word_reg <= saved_user_status_word_next;
         saved_a_reg <= saved_a_next;
         user_sp_reg <= user_sp_next;
         state_reg <= state_next;
         pendCmd_reg <= pendCmd_next;
         memReq <= memReq_next;
         memWrite <= memWrite_next;
         memSize <= memSize_next;
         memAddr <= memAddr_next;
         memWdata <= memWdata_next;
         targetReset <= targetReset_next;
         userRunning <= run_flag_next;
      end
   end

   // AHB-Lite slave: zero wait states, always OKAY
   wire addrPhase = hsel && hready && htrans[1];
   wire busWrite = dphValid_reg && dphWrite_reg;
   wire hostRxWr = busWrite && (dphAddr_reg == `SDM_ADDR_RXDATA);
   wire hostTxRd = addrPhase && !hwrite && (haddr == `SDM_ADDR_TXDATA) && txFull_reg;

   // Received-character mailbox; write while full is dropped
   always @(posedge sys_clk) begin
      if (!rst_b) begin
         rxChar_reg <= 8'h00;
         rxFull_reg <= 1'b0;
      end else if (hostRxWr && !rxFull_reg) begin
         rxChar_reg <= hwdata[7:0];
         rxFull_reg <= 1'b1;
      end else if (rxTake) begin
         rxFull_reg <= 1'b0;
      end
   end

   // Transmit mailbox; filled only by the transmit command, emptied by a host read
   always @(posedge sys_clk) begin
      if (!rst_b) begin
         txData_reg <= 8'h00;
         txFull_reg <= 1'b0;
      end else if (txLoad) begin
         txData_reg <= shift_data_reg[7:0];
         txFull_reg <= 1'b1;
      end else if (hostTxRd) begin
         txFull_reg <= 1'b0;
      end
   end

   // Bus phase tracking and read mux
   always @(posedge sys_clk) begin
      if (!rst_b) begin
         dphValid_reg <= 1'b0;
         dphWrite_reg <= 1'b0;
         dphAddr_reg <= 32'h0000_0000;
         hrdata <= 32'h0000_0000;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end else begin
         dphValid_reg <= addrPhase;
         dphWrite_reg <= hwrite;
         dphAddr_reg <= haddr;
         if (addrPhase && !hwrite) begin
            case (haddr)
               `SDM_ADDR_RXDATA: hrdata <= {24'h000000, rxChar_reg};
               `SDM_ADDR_RXSTAT: hrdata <= {31'h00000000, rxFull_reg};
               `SDM_ADDR_TXDATA: hrdata <= {23'h000000, txFull_reg, txData_reg};
               `SDM_ADDR_STATE: hrdata <= {26'h0000000, busy, txFull_reg, rxFull_reg,
                  halt_flag_reg, run_flag_reg, literal_next_flag_reg};
               `SDM_ADDR_SHIFT: hrdata <= shift_data_reg;
               `SDM_ADDR_TADDR: hrdata <= {16'h0000, target_addr_reg};
               `SDM_ADDR_USTAT: hrdata <= {16'h0000, saved_user_status_word_reg};
               `SDM_ADDR_UPC: hrdata <= {16'h0000, saved_a_reg};
               `SDM_ADDR_USP: hrdata <= {16'h0000, user_sp_reg};
               default: hrdata <= 32'h0000_0000;
            endcase
         end
      end
   end
endmodule
`default_nettype wire

// file: verification/sdm_debug_monitor_chk.sv
// Port checks for the debug monitor
`timescale 1ns/1ps
`default_nettype none
module sdm_debug_monitor_chk (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst_b,
   // Bus answer
   input wire logic hreadyout,
   input wire logic hresp,
   // Memory port
   input wire logic memReq,
   input wire logic memWrite,
   input wire logic [1:0] memSize,
   input wire logic [15:0] memAddr,
   input wire logic [31:0] memWdata,
   input wire logic memAck,
   // Context
   input wire logic breakpointEntry,
   input wire logic targetReset,
   input wire logic userRunning
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_b);
   // Request waiting for its acknowledge
   sequence reqPending;
      memReq && !memAck;
   endsequence
   // Write completing now
   sequence writeDone;
      memReq && memAck && memWrite;
   endsequence
   AST_BUS_OKAY: assert property (hreadyout && !hresp)
      else $error("bus not zero-wait OKAY");
   AST_REQ_HELD: assert property (reqPending |=> memReq && $stable({memWrite, memSize, memAddr, memWdata}))
      else $error("request moved before ack");
   AST_SIZE_LEGAL: assert property (memReq |-> memSize <= 2'h2)
      else $error("bad access size");
   AST_WR_ONCE: assert property (writeDone |=> !(memReq && memWrite && $stable(memAddr)))
      else $error("write repeated");
   AST_BRK_STOP: assert property ($rose(breakpointEntry) && userRunning && !memReq |-> ##[1:8] !userRunning)
      else $error("breakpoint did not stop");
   AST_BRK_IDLE: assert property (breakpointEntry && !userRunning |=> !userRunning)
      else $error("breakpoint started code");
   AST_TRST_PULSE: assert property (targetReset |=> !targetReset)
      else $error("reset pulse too long");
   AST_TRST_QUIET: assert property (targetReset |-> !memReq)
      else $error("reset during access");
endmodule
bind sdm_debug_monitor sdm_debug_monitor_chk sdm_debug_monitor_chk_inst (.sys_clk(sys_clk), .rst_b(rst_b),
   .hreadyout(hreadyout), .hresp(hresp), .memReq(memReq), .memWrite(memWrite), .memSize(memSize),
   .memAddr(memAddr), .memWdata(memWdata), .memAck(memAck), .breakpointEntry(breakpointEntry),
   .targetReset(targetReset), .userRunning(userRunning));
`default_nettype wire

// file: verification/sdm_mem_model.sv
// Target memory model on the monitor's memory port
`timescale 1ns/1ps
`default_nettype none
module sdm_mem_model (
   // Clock and pacing
   input wire logic sys_clk,
   input wire logic [3:0] waitCycles,
   // Request
   input wire logic memReq,
   input wire logic memWrite,
   input wire logic [1:0] memSize,
   input wire logic [15:0] memAddr,
   input wire logic [31:0] memWdata,
   // Answer
   output logic memAck,
   output logic [31:0] memRdata
);
   logic [7:0] mem [0:65535];
   int waitCnt = 0;
   // Each byte starts as its own low address byte
   initial begin
      for (int i = 0; i < 65536; i++) mem[i] = i[7:0];
      memAck = 1'b0;
      memRdata = 32'h0;
   end
   // Ack after the set wait; read data is only valid with the ack
   always @(posedge sys_clk) begin
      memAck <= 1'b0;
      memRdata <= ~memRdata;
      if (memReq && !memAck) begin
         waitCnt <= waitCnt + 1;
         if (waitCnt >= waitCycles) begin
            waitCnt <= 0;
            memAck <= 1'b1;
            for (int b = 0; b < 4; b++) begin
               memRdata[8*b +: 8] <= mem[16'(memAddr + b)];
               if (memWrite && b < (1 << memSize)) mem[16'(memAddr + b)] <= memWdata[8*b +: 8];
            end
         end
      end
   end
endmodule
`default_nettype wire

// file: verification/sdm_debug_monitor_tb.sv
// Self-checking bench for the debug monitor
`timescale 1ns/1ps
`default_nettype none
`include "sdm_map.vh"
module sdm_debug_monitor_tb;
   typedef struct packed {logic [7:0] c; logic [31:0] s; logic [15:0] a;} sdm_row_t;
   logic sys_clk = 1'b0;
   logic rst_b = 1'b0;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [2:0] hsize = 3'h2;
   logic [31:0] hwdata = 32'h0;
   logic brk = 1'b0;
   logic [15:0] liveSw = 16'h1234;
   logic [15:0] livePc = 16'h2080;
   logic [3:0] waitCycles = 4'h0;
   wire [31:0] hrdata, memWdata, memRdata;
   wire hreadyout, hresp, memReq, memWrite, memAck, targetReset, userRunning;
   wire [1:0] memSize;
   wire [15:0] memAddr;
   int err_count = 0;
   int n_tests = 0;
   int pulses = 0;
   logic [31:0] prevS = 32'h0;
   // Byte sent, data register and address expected after it
   sdm_row_t rows [24] = '{'{8'h41, 32'h41, 16'h0}, '{8'h42, 32'h4142, 16'h0}, '{8'h43, 32'h414243, 16'h0},
      '{8'h44, 32'h41424344, 16'h0}, '{8'h45, 32'h42434445, 16'h0}, '{8'h00, 32'h42434445, 16'h0},
      '{8'h05, 32'h43444505, 16'h0}, '{8'h0a, 32'h43444505, 16'h4505}, '{8'h09, 32'h43444505, 16'h4509},
      '{8'h01, 32'h43444505, 16'h4509}, '{8'h02, 32'h434445, 16'h450a}, '{8'h07, 32'h434445, 16'h450b},
      '{8'h08, 32'h434445, 16'h450d}, '{8'h45, 32'h43444545, 16'h450d}, '{8'h00, 32'h43444545, 16'h450d},
      '{8'h05, 32'h44454505, 16'h450d}, '{8'h0a, 32'h44454505, 16'h4505}, '{8'h06, 32'h43444505, 16'h4505},
      '{8'h02, 32'h434445, 16'h4506}, '{8'h02, 32'h4344, 16'h4507}, '{8'h0b, 32'h4344, 16'h4344},
      '{8'h05, 32'h4544, 16'h4344}, '{8'h07, 32'h4544, 16'h4345}, '{8'h04, 32'h4545, 16'h4345}};
   sdm_debug_monitor sdm_debug_monitor_inst (.sys_clk(sys_clk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .memReq(memReq), .memWrite(memWrite), .memSize(memSize),
      .memAddr(memAddr), .memWdata(memWdata), .memAck(memAck), .memRdata(memRdata), .breakpointEntry(brk),
      .liveStatusWord(liveSw), .livePc(livePc), .targetReset(targetReset), .userRunning(userRunning));
   sdm_mem_model sdm_mem_model_inst (.sys_clk(sys_clk), .waitCycles(waitCycles), .memReq(memReq),
      .memWrite(memWrite), .memSize(memSize), .memAddr(memAddr), .memWdata(memWdata), .memAck(memAck),
      .memRdata(memRdata));
   // Clock and target reset pulse count
   always #20 sys_clk = ~sys_clk;
   always @(posedge sys_clk) if (targetReset === 1'b1) pulses++;
   task automatic stop_test;
      $display("Checks %0d, mismatches %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         err_count++;
         $display("ERROR %0t got %h want %h", $time, got, exp);
      end
   endtask
   // One single word transfer; read data taken at the data phase's ready edge
   task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] d, output logic [31:0] q);
      @(posedge sys_clk);
      hsel <= 1'b1;
      haddr <= a;
      htrans <= 2'h2;
      hwrite <= wr;
      @(posedge sys_clk);
      while (hreadyout !== 1'b1) @(posedge sys_clk);
      htrans <= 2'h0;
      hwdata <= d;
      @(posedge sys_clk);
      while (hreadyout !== 1'b1) @(posedge sys_clk);
      q = hrdata;
   endtask
   task automatic rdchk(input logic [31:0] a, input logic [31:0] e, input logic [31:0] m);
      logic [31:0] q;
      ahb(1'b0, a, 32'h0, q);
      chk(q & m, e);
   endtask
   // Hand in a character, then poll until it has been acted on
   task automatic send(input logic [7:0] c);
      logic [31:0] q;
      ahb(1'b1, `SDM_ADDR_RXDATA, {24'h0, c}, q);
      q = 32'h28;
      while (q[5] | q[3]) ahb(1'b0, `SDM_ADDR_STATE, 32'h0, q);
   endtask
   initial begin
      repeat (20000) @(posedge sys_clk);
      err_count++;
      stop_test();
   end
   initial begin
      repeat (6) @(posedge sys_clk);
      rst_b <= 1'b1;
      rdchk(`SDM_ADDR_STATE, 32'h0, 32'h3f);
      rdchk(32'h40, 32'h0, 32'hffff_ffff);
      for (int i = 0; i < 24; i++) begin
         if (i == 12) waitCycles <= 4'h3;
         send(rows[i].c);
         rdchk(`SDM_ADDR_SHIFT, rows[i].s, 32'hffff_ffff);
         rdchk(`SDM_ADDR_TADDR, {16'h0, rows[i].a}, 32'hffff_ffff);
         if (rows[i].c == `SDM_CMD_TRANSMIT)
            rdchk(`SDM_ADDR_TXDATA, {23'h1, prevS[7:0]}, 32'h1ff);
         else
            rdchk(`SDM_ADDR_TXDATA, 32'h0, 32'h100);
         prevS = rows[i].s;
      end
      send(8'h14);
      rdchk(`SDM_ADDR_SHIFT, `SDM_STAT_STOPPED, 32'hffff_ffff);
      send(8'h12);
      chk(userRunning, 32'h1);
      send(8'h14);
      rdchk(`SDM_ADDR_SHIFT, `SDM_STAT_RUNNING, 32'hffff);
      send(8'h10);
      rdchk(`SDM_ADDR_SHIFT, livePc, 32'hffff);
      send(8'h0c);
      rdchk(`SDM_ADDR_SHIFT, liveSw, 32'hffff);
      // Breakpoint while idle and running
      @(posedge sys_clk);
      brk <= 1'b1;
      @(posedge sys_clk);
      brk <= 1'b0;
      for (int k = 0; k < 20 && userRunning; k++) @(posedge sys_clk);
      chk(userRunning, 32'h0);
      rdchk(`SDM_ADDR_UPC, livePc, 32'hffff);
      rdchk(`SDM_ADDR_USTAT, liveSw, 32'hffff);
      send(8'h14);
      rdchk(`SDM_ADDR_SHIFT, `SDM_STAT_TRAPPED, 32'hffff);
      send(8'h12);
      send(8'h14);
      rdchk(`SDM_ADDR_SHIFT, `SDM_STAT_RUNNING, 32'hffff);
      send(8'h13);
      chk(userRunning, 32'h0);
      send(8'h14);
      rdchk(`SDM_ADDR_SHIFT, `SDM_STAT_STOPPED, 32'hffff);
      send(8'h00);
      send(8'h01);
      send(8'h15);
      chk(pulses, 32'h1);
      // Stack pointer 5000h gets the idle context pushed below it
      send(8'h50);
      send(8'h00);
      send(8'h00);
      send(8'h0f);
      rdchk(`SDM_ADDR_USP, 32'h4ffc, 32'hffff);
      chk({sdm_mem_model_inst.mem[16'h4fff], sdm_mem_model_inst.mem[16'h4ffe]}, 32'h0);
      chk({sdm_mem_model_inst.mem[16'h4ffd], sdm_mem_model_inst.mem[16'h4ffc]}, 32'h0);
      send(8'h0e);
      rdchk(`SDM_ADDR_SHIFT, 32'h4ffc, 32'hffff);
      // Context writes while stopped; stopped reads must return the saved copies
      send(8'h56);
      send(8'h78);
      send(8'h0d);
      rdchk(`SDM_ADDR_USTAT, 32'h5678, 32'hffff);
      send(8'h39);
      send(8'h2a);
      send(8'h11);
      rdchk(`SDM_ADDR_UPC, 32'h392a, 32'hffff);
      send(8'h0c);
      rdchk(`SDM_ADDR_SHIFT, 32'h5678, 32'hffff);
      send(8'h10);
      rdchk(`SDM_ADDR_SHIFT, 32'h392a, 32'hffff);
      // A breakpoint while stopped must neither halt nor start anything
      @(posedge sys_clk);
      brk <= 1'b1;
      @(posedge sys_clk);
      brk <= 1'b0;
      send(8'h14);
      rdchk(`SDM_ADDR_SHIFT, `SDM_STAT_STOPPED, 32'hffff);
      // Reset in mid-run clears the working registers
      @(posedge sys_clk);
      rst_b <= 1'b0;
      repeat (2) @(posedge sys_clk);
      rst_b <= 1'b1;
      rdchk(`SDM_ADDR_STATE, 32'h0, 32'h3f);
      rdchk(`SDM_ADDR_SHIFT, 32'h0, 32'hffff_ffff);
      rdchk(`SDM_ADDR_TADDR, 32'h0, 32'hffff_ffff);
      rdchk(`SDM_ADDR_USP, 32'h0, 32'hffff_ffff);
      stop_test();
   end
endmodule
`default_nettype wire
